// ### hdl/tweps_defs.vh
// constants of the two-wire eeprom target engine
// assumes inclusion by bare name from the design files
`ifndef TWEPS_DEFS_VH
`define TWEPS_DEFS_VH

// device address word
`define TWEPS_TYPE_CODE      4'hA
`define TWEPS_DIR_READ       1'b1
// word address and page layout
`define TWEPS_ADDR_W         15
`define TWEPS_PAGE_BITS      6
`define TWEPS_ARRAY_DEPTH    32768
`define TWEPS_HI_ADDR_MASK   7'h7F
// bit counter
`define TWEPS_BIT_LAST       4'h7
`define TWEPS_BIT_ACK        4'h8
// write cycle time, microseconds, and clock rate
`define TWEPS_WR_TIME_US     5000
`define TWEPS_CLK_MHZ        200
`define TWEPS_WR_CNT_W       20
// engine states
`define TWEPS_ST_IDLE        3'h0
`define TWEPS_ST_DEVADR      3'h1
`define TWEPS_ST_ADRHI       3'h2
`define TWEPS_ST_ADRLO       3'h3
`define TWEPS_ST_WDATA       3'h4
`define TWEPS_ST_RDATA       3'h5

`endif

// ### hdl/tweps_sync.v
// two-flop synchroniser with edge detection for the serial pins
// assumes pins are asynchronous to ref_clk
`timescale 1ns/10ps

module tweps_sync
(
    // clock and reset
    input  wire       ref_clk,
    input  wire       arst_n,
    // raw pin level
    input  wire       pin_in,
    // synchronised level and edges
    output reg        level,
    output wire       rise,
    output wire       fall
);

reg meta;
reg prev;

// -----------------------------------------------------------
// two flops, then an edge-detect stage
// -----------------------------------------------------------
// idle bus level is high
always @(posedge ref_clk or negedge arst_n)
begin
    if (!arst_n)
    begin
        meta  <= 1'b1;
        level <= 1'b1;
        prev  <= 1'b1;
    end
    else
    begin
        meta  <= pin_in;
        level <= meta;
        prev  <= level;
    end
end

// edges seen on the synchronised level only
assign rise = level & ~prev;
assign fall = ~level & prev;

endmodule // tweps_sync

// ### hdl/tweps_engine.v
// two-wire serial eeprom target protocol engine with its memory array
// assumes the bus controller drives scl and the sda wire is pulled up
`timescale 1ns/10ps
`include "tweps_defs.vh"

module tweps_engine
#(
    parameter WR_CYCLES = `TWEPS_WR_TIME_US * `TWEPS_CLK_MHZ
)
(
    // clock and reset
    input  wire       ref_clk,
    input  wire       arst_n,
    // serial bus pins
    input  wire       scl_in,
    input  wire       sda_in,
    output reg        sda_out,
    output reg        sda_oe,
    // strap and protect pins
    input  wire       chip_select_bit2,
    input  wire       chip_select_bit1,
    input  wire       chip_select_bit0,
    input  wire       write_protect,
    // status
    output reg        write_busy,
    output wire       standby
);

// -----------------------------------------------------------
// declarations
// -----------------------------------------------------------
reg  [7:0]                  mem [0:`TWEPS_ARRAY_DEPTH-1];
reg  [7:0]                  page_buf [0:(1<<`TWEPS_PAGE_BITS)-1];
reg  [(1<<`TWEPS_PAGE_BITS)-1:0] page_dirty;
reg  [2:0]                  state;
reg  [3:0]                  bit_cnt;
reg  [7:0]                  shreg;
reg  [`TWEPS_ADDR_W-1:0]    addr_cnt;
reg  [`TWEPS_ADDR_W-1:0]    page_base;
reg                         pend_write;
reg                         ack_phase;
reg                         is_read;
reg                         host_nack;
reg  [`TWEPS_WR_CNT_W-1:0]  wr_cnt;
reg  [`TWEPS_PAGE_BITS:0]   flush_idx;
reg                         flushing;
reg  [2:0]                  cs_sync1;
reg  [2:0]                  cs_sync2;
reg                         wp_sync1;
reg                         wp_sync2;
wire                        scl;
wire                        scl_rise;
wire                        scl_fall;
wire                        sda;
wire                        sda_rise;
wire                        sda_fall;
wire                        start_cond;
wire                        stop_cond;
wire                        addr_match;
integer                     i;

// -----------------------------------------------------------
// pin synchronisers
// -----------------------------------------------------------
tweps_sync u_scl_sync
(
    .ref_clk (ref_clk),
    .arst_n  (arst_n),
    .pin_in  (scl_in),
    .level   (scl),
    .rise    (scl_rise),
    .fall    (scl_fall)
);

tweps_sync u_sda_sync
(
    .ref_clk (ref_clk),
    .arst_n  (arst_n),
    .pin_in  (sda_in),
    .level   (sda),
    .rise    (sda_rise),
    .fall    (sda_fall)
);

// straps and protect pin pass two flops
always @(posedge ref_clk or negedge arst_n)
begin
    if (!arst_n)
    begin
        cs_sync1 <= 3'h0;
        cs_sync2 <= 3'h0;
        wp_sync1 <= 1'b0;
        wp_sync2 <= 1'b0;
    end
    else
    begin
        cs_sync1 <= {chip_select_bit2, chip_select_bit1, chip_select_bit0};
        cs_sync2 <= cs_sync1;
        wp_sync1 <= write_protect;
        wp_sync2 <= wp_sync1;
    end
end

// -----------------------------------------------------------
// bus conditions and address decode
// -----------------------------------------------------------
// data edges while the clock stays high
assign start_cond = sda_fall & scl;
assign stop_cond  = sda_rise & scl;

// type code then chip selects
function dev_match;
    input [6:0] adr;
    input [2:0] cs;
    begin
        dev_match = (adr[6:3] == `TWEPS_TYPE_CODE) && (adr[2:0] == cs);
    end
endfunction

// upper nibble and selects compared on the shifted word
assign addr_match = dev_match(shreg[7:1], cs_sync2);

assign standby = (state == `TWEPS_ST_IDLE) & ~write_busy;

// -----------------------------------------------------------
// main protocol engine
// -----------------------------------------------------------
// bits sampled on scl rise, sda driven after scl fall
always @(posedge ref_clk or negedge arst_n)
begin
    if (!arst_n)
    begin
        state      <= `TWEPS_ST_IDLE;
        bit_cnt    <= 4'h0;
        shreg      <= 8'h00;
        addr_cnt   <= {`TWEPS_ADDR_W{1'b0}};
        page_base  <= {`TWEPS_ADDR_W{1'b0}};
        pend_write <= 1'b0;
        page_dirty <= {(1<<`TWEPS_PAGE_BITS){1'b0}};
        ack_phase  <= 1'b0;
        is_read    <= 1'b0;
        host_nack  <= 1'b0;
        sda_out    <= 1'b1;
        sda_oe     <= 1'b0;
        write_busy <= 1'b0;
        wr_cnt     <= {`TWEPS_WR_CNT_W{1'b0}};
        flushing   <= 1'b0;
        flush_idx  <= {(`TWEPS_PAGE_BITS+1){1'b0}};
    end
    else if (write_busy)
    begin
        // bus ignored and nothing driven while writing
        sda_oe  <= 1'b0;
        sda_out <= 1'b1;
        state   <= `TWEPS_ST_IDLE;
        if (flushing)
        begin
            if (page_dirty[flush_idx[`TWEPS_PAGE_BITS-1:0]])
                mem[page_base | flush_idx[`TWEPS_PAGE_BITS-1:0]]
                    <= page_buf[flush_idx[`TWEPS_PAGE_BITS-1:0]];
            flush_idx <= flush_idx + 1'b1;
            if (flush_idx == (1 << `TWEPS_PAGE_BITS) - 1)
                flushing <= 1'b0;
        end
        if (wr_cnt == WR_CYCLES - 1)
        begin
            write_busy <= 1'b0;
            page_dirty <= {(1<<`TWEPS_PAGE_BITS){1'b0}};
        end
        else
            wr_cnt <= wr_cnt + 1'b1;
    end
    else if (start_cond)
    begin
        // every start begins with a device address word
        state      <= `TWEPS_ST_DEVADR;
        bit_cnt    <= 4'h0;
        ack_phase  <= 1'b0;
        sda_oe     <= 1'b0;
        pend_write <= 1'b0;
        page_dirty <= {(1<<`TWEPS_PAGE_BITS){1'b0}};
    end
    else if (stop_cond)
    begin
        state  <= `TWEPS_ST_IDLE;
        sda_oe <= 1'b0;
        // protected array skips the cycle
        if (pend_write && !wp_sync2)
        begin
            write_busy <= 1'b1;
            wr_cnt     <= {`TWEPS_WR_CNT_W{1'b0}};
            flushing   <= 1'b1;
            flush_idx  <= {(`TWEPS_PAGE_BITS+1){1'b0}};
        end
        pend_write <= 1'b0;
    end
    else if (state != `TWEPS_ST_IDLE)
    begin
        if (scl_rise)
        begin
            // read data bits are driven, not shifted in
            if (!ack_phase && state != `TWEPS_ST_RDATA)
            begin
                shreg   <= {shreg[6:0], sda};
                bit_cnt <= bit_cnt + 1'b1;
            end
            else if (ack_phase && state == `TWEPS_ST_RDATA)
                host_nack <= sda;
        end
        else if (scl_fall)
        begin
            if (ack_phase)
            begin
                // end of ninth clock
                ack_phase <= 1'b0;
                bit_cnt   <= 4'h0;
                sda_oe    <= 1'b0;
                if (state == `TWEPS_ST_RDATA)
                begin
                    if (host_nack)
                        state <= `TWEPS_ST_IDLE;
                    else
                    begin
                        // drive next byte msb
                        shreg   <= mem[addr_cnt];
                        sda_oe  <= ~mem[addr_cnt][7];
                        sda_out <= 1'b0;
                        addr_cnt <= addr_cnt + 1'b1;
                        bit_cnt <= 4'h0;
                    end
                end
            end
            else if (state == `TWEPS_ST_RDATA)
            begin
                if (bit_cnt == `TWEPS_BIT_LAST)
                begin
                    // eighth bit clocked: release for host acknowledge
                    sda_oe    <= 1'b0;
                    ack_phase <= 1'b1;
                    bit_cnt   <= `TWEPS_BIT_ACK;
                end
                else
                begin
                    // shift out next bit, open drain
                    sda_oe  <= ~shreg[6];
                    shreg   <= {shreg[6:0], 1'b1};
                    bit_cnt <= bit_cnt + 1'b1;
                end
            end
            else if (bit_cnt == `TWEPS_BIT_ACK)
            begin
                // eight bits in: decide on acknowledge
                ack_phase <= 1'b1;
                sda_out   <= 1'b0;
                case (state)
                    `TWEPS_ST_DEVADR:
                    begin
                        if (addr_match)
                        begin
                            sda_oe  <= 1'b1;
                            is_read <= (shreg[0] == `TWEPS_DIR_READ);
                            state   <= (shreg[0] == `TWEPS_DIR_READ) ?
                                       `TWEPS_ST_RDATA : `TWEPS_ST_ADRHI;
                            host_nack <= 1'b0;
                        end
                        else
                        begin
                            sda_oe    <= 1'b0;
                            ack_phase <= 1'b0;
                            state     <= `TWEPS_ST_IDLE;
                        end
                    end
                    `TWEPS_ST_ADRHI:
                    begin
                        sda_oe   <= 1'b1;
                        // bits above the array ignored
                        addr_cnt <= {shreg[6:0] & `TWEPS_HI_ADDR_MASK,
                                     addr_cnt[7:0]};
                        state    <= `TWEPS_ST_ADRLO;
                    end
                    `TWEPS_ST_ADRLO:
                    begin
                        sda_oe   <= 1'b1;
                        addr_cnt <= {addr_cnt[14:8], shreg};
                        state    <= `TWEPS_ST_WDATA;
                    end
                    `TWEPS_ST_WDATA:
                    begin
                        sda_oe <= 1'b1;
                        page_buf[addr_cnt[`TWEPS_PAGE_BITS-1:0]] <= shreg;
                        page_dirty[addr_cnt[`TWEPS_PAGE_BITS-1:0]] <= 1'b1;
                        page_base <= {addr_cnt[14:6], {`TWEPS_PAGE_BITS{1'b0}}};
                        pend_write <= 1'b1;
                        // only the page offset advances
                        addr_cnt[`TWEPS_PAGE_BITS-1:0] <=
                            addr_cnt[`TWEPS_PAGE_BITS-1:0] + 1'b1;
                    end
                    default:
                    begin
                        sda_oe <= 1'b0;
                        state  <= `TWEPS_ST_IDLE;
                    end
                endcase
            end
        end
    end
end

// -----------------------------------------------------------
// read start: after device ack the first byte goes out
// -----------------------------------------------------------
// handled by forcing host_nack low above; first byte loads at
// the fall closing the device-address ack, as for later bytes
// (the ack cycle of the address behaves like a host ack).

endmodule // tweps_engine

// ### verification/tweps_chk.sv
// assertion checker for the two-wire eeprom target engine ports
// assumes one ref_clk domain and bind onto tweps_engine
`timescale 1ns/10ps
module tweps_chk
#(
    parameter WR_CYCLES = 200
)
(
    // clock and reset
    input wire        ref_clk,
    input wire        arst_n,
    // serial bus
    input wire        scl_in,
    input wire        sda_in,
    input wire        sda_out,
    input wire        sda_oe,
    // protect and status
    input wire        write_protect,
    input wire        write_busy,
    input wire        standby
);
    reg [19:0]        busy_len;
    // ------------------------------------------------------------
    // length of the write cycle
    // ------------------------------------------------------------
    always @(posedge ref_clk or negedge arst_n)
        if (!arst_n)
            busy_len <= 20'h0;
        else if (write_busy)
            busy_len <= busy_len + 20'h1;
        else
            busy_len <= 20'h0;

    default clocking @(posedge ref_clk); endclocking
    default disable iff (!arst_n);
    // stop on the pins, data rising while clock high
    sequence stop_cond;
        scl_in && $rose(sda_in);
    endsequence

    oe_drives_low_a: assert property (sda_oe |-> !sda_out)
        else $error("driven data line not low");
    oe_hold_a: assert property ($rose(sda_oe) |-> sda_oe [*8])
        else $error("acknowledge dropped early");
    oe_edge_a: assert property ($changed(sda_oe) |-> !scl_in)
        else $error("data drive changed with clock high");
    busy_silent_a: assert property (write_busy |-> !sda_oe)
        else $error("drive during write cycle");
    busy_standby_a: assert property (write_busy |-> !standby)
        else $error("standby during write cycle");
    busy_span_a: assert property ($fell(write_busy) && busy_len != 20'h0
        |-> busy_len == WR_CYCLES)
        else $error("write cycle length wrong");
    wp_no_cycle_a: assert property ($rose(write_busy) |-> !write_protect)
        else $error("write cycle while protected");
    stop_idle_a: assert property (stop_cond |-> ##[2:10] (standby || write_busy))
        else $error("no standby or write after stop");
    busy_end_idle_a: assert property ($fell(write_busy) |-> standby)
        else $error("no standby after write cycle");
endmodule // tweps_chk

bind tweps_engine tweps_chk #(.WR_CYCLES(WR_CYCLES)) tweps_chk_i
(
    .ref_clk(ref_clk), .arst_n(arst_n), .scl_in(scl_in), .sda_in(sda_in),
    .sda_out(sda_out), .sda_oe(sda_oe), .write_protect(write_protect),
    .write_busy(write_busy), .standby(standby)
);

// ### verification/tweps_ctl_model.sv
// behavioural two-wire bus controller driving clock and data
// assumes the data wire is resolved with its pull-up by the bench
`timescale 1ns/10ps
module tweps_ctl_model
(
    // resolved data wire
    input wire        sda,
    // controller drive
    output reg        scl,
    output reg        sda_low
);
    localparam Q = 16;  // quarter of the 64 ns clock
    // clock stands high between frames
    initial
    begin
        scl = 1'b1;
        sda_low = 1'b0;
    end
    // data falls with clock high, also as repeated start
    task put_start;
        begin
            sda_low <= 1'b0;
            #Q scl <= 1'b1;
            #Q sda_low <= 1'b1;
            #Q scl <= 1'b0;
            #Q;
        end
    endtask
    // data rises with clock high, clock then stands
    task put_stop;
        begin
            sda_low <= 1'b1;
            #Q scl <= 1'b1;
            #Q sda_low <= 1'b0;
            #Q;
        end
    endtask
    // one clock: drive in low half, sample in high half
    task bit_io(input b, output r);
        begin
            sda_low <= !b;
            #Q scl <= 1'b1;
            #Q r = sda;
            #Q scl <= 1'b0;
            #Q;
        end
    endtask
    // eight bits msb first, ninth clock returns the acknowledge
    task send(input [7:0] d, output nak);
        integer i;
        reg     r;
        begin
            for (i = 7; i >= 0; i = i - 1)
                bit_io(d[i], r);
            bit_io(1'b1, nak);
        end
    endtask
    // eight bits in, then own acknowledge or none
    task recv(input ack_n, output [7:0] d);
        integer i;
        reg     r;
        begin
            for (i = 7; i >= 0; i = i - 1)
            begin
                bit_io(1'b1, r);
                d[i] = r;
            end
            bit_io(ack_n, r);
        end
    endtask
endmodule // tweps_ctl_model

// ### verification/tweps_engine_tb.sv
// self-checking bench for the two-wire eeprom target engine
// assumes a pull-up on data and a controller model on the bus
`timescale 1ns/10ps
module tweps_engine_tb;
    reg               ref_clk = 1'b0;
    reg               arst_n = 1'b0;
    reg               write_protect = 1'b0;
    reg [2:0]         cs = 3'h5;
    wire              scl, ctl_low, sda_out, sda_oe, write_busy, standby;
    wire              sda = !(ctl_low || (sda_oe && !sda_out));
    reg [7:0]         mem [0:32767];
    integer           fail_count = 0;
    integer           samples_checked = 0;
    // ------------------------------------------------------------
    // units
    // ------------------------------------------------------------
    tweps_engine #(.WR_CYCLES(200)) tweps_engine_i
    (
        .ref_clk(ref_clk), .arst_n(arst_n), .scl_in(scl), .sda_in(sda),
        .sda_out(sda_out), .sda_oe(sda_oe), .chip_select_bit2(cs[2]),
        .chip_select_bit1(cs[1]), .chip_select_bit0(cs[0]),
        .write_protect(write_protect), .write_busy(write_busy), .standby(standby)
    );
    tweps_ctl_model tweps_ctl_model_i (.sda(sda), .scl(scl), .sda_low(ctl_low));
    // 200 MHz clock
    initial
        forever #2.5 ref_clk = !ref_clk;
    // compare tasks
    task chk_bit(input string nm, input logic e, input logic g);
        begin
            samples_checked = samples_checked + 1;
            if (g !== e)
            begin
                $display("unexpected %s expected %b seen %b", nm, e, g);
                fail_count = fail_count + 1;
            end
        end
    endtask
    task chk_byte(input string nm, input logic [7:0] e, input logic [7:0] g);
        begin
            samples_checked = samples_checked + 1;
            if (g !== e)
            begin
                $display("unexpected %s expected %h seen %h", nm, e, g);
                fail_count = fail_count + 1;
            end
        end
    endtask
    // ------------------------------------------------------------
    // bus helpers
    // ------------------------------------------------------------
    task dev(input dir, input exp_nak);
        reg n;
        begin
            tweps_ctl_model_i.put_start;
            tweps_ctl_model_i.send({4'hA, cs, dir}, n);
            chk_bit("device ack", exp_nak, n);
        end
    endtask
    task addr(input [15:0] a);
        reg n;
        begin
            dev(1'b0, 1'b0);
            tweps_ctl_model_i.send(a[15:8], n);
            chk_bit("high address ack", 1'b0, n);
            tweps_ctl_model_i.send(a[7:0], n);
            chk_bit("low address ack", 1'b0, n);
        end
    endtask
    // poll, on ack read one byte to finish the frame
    task poll(input exp_nak);
        reg [7:0] d;
        begin
            dev(1'b1, exp_nak);
            if (!exp_nak)
                tweps_ctl_model_i.recv(1'b1, d);
            tweps_ctl_model_i.put_stop;
        end
    endtask
    task wr(input [15:0] a, input integer n, input [7:0] base);
        integer i;
        reg     k;
        begin
            addr(a);
            for (i = 0; i < n; i = i + 1)
            begin
                tweps_ctl_model_i.send(base + i, k);
                chk_bit("data ack", 1'b0, k);
                if (!write_protect)
                    mem[{a[14:6], a[5:0] + i[5:0]}] = base + i;
            end
            tweps_ctl_model_i.put_stop;
            repeat (20) @(posedge ref_clk);
            chk_bit("write busy", !write_protect, write_busy);
            poll(!write_protect);
            for (i = 0; i < 400 && write_busy; i = i + 1)
                @(posedge ref_clk);
            poll(1'b0);
        end
    endtask
    // random read then sequential bytes, then current read
    task rd(input [15:0] a, input integer n);
        integer i;
        reg [7:0] d;
        begin
            addr(a);
            dev(1'b1, 1'b0);
            for (i = 0; i < n; i = i + 1)
            begin
                tweps_ctl_model_i.recv(i == n - 1, d);
                chk_byte("read data", mem[(a[14:0] + i) & 15'h7FFF], d);
            end
            tweps_ctl_model_i.put_stop;
            dev(1'b1, 1'b0);
            tweps_ctl_model_i.recv(1'b1, d);
            chk_byte("current read", mem[(a[14:0] + n) & 15'h7FFF], d);
            tweps_ctl_model_i.put_stop;
        end
    endtask
    // wrong type code and wrong chip select are ignored
    task t_mismatch;
        reg n;
        begin
            tweps_ctl_model_i.put_start;
            tweps_ctl_model_i.send({4'h5, cs, 1'b0}, n);
            chk_bit("type mismatch", 1'b1, n);
            tweps_ctl_model_i.put_start;
            tweps_ctl_model_i.send({4'hA, cs ^ 3'h1, 1'b1}, n);
            chk_bit("select mismatch", 1'b1, n);
            tweps_ctl_model_i.put_stop;
            chk_bit("standby", 1'b1, standby);
        end
    endtask
    task close_out;
        begin
            $display("checks %0d mismatches %0d", samples_checked, fail_count);
            if (fail_count == 0 && samples_checked > 0)
                $display("bench passed");
            else
                $display("bench failed");
            $finish;
        end
    endtask
    // ------------------------------------------------------------
    // sequence and watchdog
    // ------------------------------------------------------------
    initial
    begin
        repeat (6) @(posedge ref_clk);
        arst_n <= 1'b1;
        repeat (4) @(posedge ref_clk);
        chk_bit("standby at start", 1'b1, standby);
        wr(16'h7FFF, 1, 8'h11);
        wr(16'h0000, 2, 8'h22);
        rd(16'hFFFF, 2);
        wr(16'h013E, 66, 8'h40);
        rd(16'h0100, 63);
        @(posedge ref_clk) write_protect <= 1'b1;
        wr(16'h0100, 2, 8'hC0);
        rd(16'h0100, 2);
        @(posedge ref_clk) write_protect <= 1'b0;
        t_mismatch;
        close_out;
    end
    initial
    begin
        #400000;
        fail_count = fail_count + 1;
        close_out;
    end
endmodule // tweps_engine_tb
